// ---- design/abg_generator.sv ----
/*
  Answer-back sequence generator: steps a 21-row coded store one row
  per distributor cycle and offers each row before the stop row to the serial transmitter
  through a two-entry buffer.
  Assumes the transmitter merges o_tx_char with keyboard and reader
  sources and honours o_line_shunt while a sequence is running.
*/
`timescale 1ns/10ps

module abg_generator #(
  parameter int CYCLE_CLKS = abg_pkg::CYCLE_CLKS,
  parameter logic [abg_pkg::ROWS*abg_pkg::LEVELS-1:0] STORE = '0
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_arst_n,
  input  wire logic                      i_rx_valid,
  input  wire logic [3:0]                i_rx_slot,
  input  wire logic                      i_rx_local,
  input  wire logic                      i_local_identify_key,
  input  wire logic                      i_ext_trip,
  input  wire logic                      i_tx_ready,
  output logic                           o_tx_valid,
  output abg_pkg::abg_char_t             o_tx_char,
  output logic                           o_line_shunt,
  output logic                           o_busy,
  output logic [abg_pkg::ROW_W-1:0]      o_row
);

  // ---------------------------------------------------------------
  // store lookup
  // ---------------------------------------------------------------
  abg_pkg::abg_state_t           state_reg;
  logic [abg_pkg::ROW_W-1:0]     row_reg;
  logic [abg_pkg::LEVELS-1:0]    row_word;
  logic [31:0]                   cnt_reg;
  logic                          trip_armed_reg;
  logic                          start;
  logic                          call_hit;
  logic                          trip_hit;
  logic                          cyc_end;
  logic                          adv_pt;

  // tine removed means programmed: a set bit marks
  always_comb begin
    row_word = STORE[row_reg*abg_pkg::LEVELS +: abg_pkg::LEVELS];
  end

  // local characters are blocked from sensing the call slot
  assign call_hit = i_rx_valid && !i_rx_local &&
                    (i_rx_slot == abg_pkg::CALL_SLOT);
  assign trip_hit = i_ext_trip && trip_armed_reg;
  assign start    = (state_reg == abg_pkg::ABG_IDLE) &&
                    (call_hit || i_local_identify_key || trip_hit);
  assign cyc_end  = (cnt_reg == 32'(CYCLE_CLKS - 1));
  assign adv_pt   = (cnt_reg == 32'(CYCLE_CLKS - abg_pkg::ADV_LEAD));

  // ---------------------------------------------------------------
  // trip latch
  // ---------------------------------------------------------------
  // must see the input drop before it can start another sequence
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      trip_armed_reg <= 1'b0;
    end else if (!i_ext_trip) begin
      trip_armed_reg <= 1'b1;
    end else if (trip_hit && start) begin
      trip_armed_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // distributor cycle counter
  // ---------------------------------------------------------------
  // a buffer stall freezes the cycle so no row is skipped
  logic                   buf_in_ready;
  logic                   hold;
  assign hold = cyc_end && !buf_in_ready;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_reg <= 32'h0000_0000;
    end else if (state_reg == abg_pkg::ABG_IDLE) begin
      cnt_reg <= 32'h0000_0000;
    end else if (hold) begin
      cnt_reg <= cnt_reg;
    end else if (cyc_end) begin
      cnt_reg <= 32'h0000_0000;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // sequence control
  // ---------------------------------------------------------------
  abg_pkg::abg_state_t    state_next;
  logic                   stop_seen_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      abg_pkg::ABG_IDLE: begin
        if (start) begin
          state_next = abg_pkg::ABG_RUN;
        end
      end
      abg_pkg::ABG_RUN: begin
        // stop row entered at this cycle's advance: finish the cycle
        if (stop_seen_reg) begin
          state_next = abg_pkg::ABG_LAST;
        end
      end
      abg_pkg::ABG_LAST: begin
        if (cyc_end && !hold) begin
          state_next = abg_pkg::ABG_IDLE;
        end
      end
      default: state_next = abg_pkg::ABG_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= abg_pkg::ABG_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // row pointer rests on the start row between sequences
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      row_reg <= abg_pkg::FIRST_ROW;
    end else if (state_reg == abg_pkg::ABG_IDLE) begin
      row_reg <= abg_pkg::FIRST_ROW;
    end else if (adv_pt && state_reg == abg_pkg::ABG_RUN) begin
      if (row_reg == abg_pkg::LAST_ROW) begin
        row_reg <= abg_pkg::FIRST_ROW;
      end else begin
        row_reg <= row_reg + 5'h01;
      end
    end
  end

  // stop mark of the row entered decides the end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stop_seen_reg <= 1'b0;
    end else if (state_reg == abg_pkg::ABG_IDLE) begin
      stop_seen_reg <= 1'b0;
    end else if (adv_pt) begin
      stop_seen_reg <= 1'b0;
    end else begin
      stop_seen_reg <= row_word[abg_pkg::LVL_STOP] &&
                       row_reg != abg_pkg::FIRST_ROW;
    end
  end

  // ---------------------------------------------------------------
  // two-entry output buffer
  // ---------------------------------------------------------------
  abg_pkg::abg_char_t     buf_reg [2];
  logic [1:0]             cnt_buf_reg;
  logic                   wr_ptr_reg;
  logic                   rd_ptr_reg;
  logic                   push;
  logic                   pop;
  abg_pkg::abg_char_t     cur_char;
  abg_pkg::abg_char_t     sensed_reg;

  // sensed row becomes one character; first row shunted
  always_comb begin
    cur_char.code  = row_word[abg_pkg::CODE_W-1:0];
    cur_char.shunt = (row_reg == abg_pkg::FIRST_ROW) ||
                     row_word[abg_pkg::LVL_SUPP];
  end

  // latched before the advance: a cycle sends the row it started on
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sensed_reg <= '0;
    end else if (adv_pt && state_reg == abg_pkg::ABG_RUN) begin
      sensed_reg <= cur_char;
    end
  end

  assign buf_in_ready = (cnt_buf_reg != 2'h2);
  assign push = cyc_end && buf_in_ready &&
                (state_reg != abg_pkg::ABG_IDLE);
  assign pop  = (cnt_buf_reg != 2'h0) && i_tx_ready;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      buf_reg[0]  <= '0;
      buf_reg[1]  <= '0;
      wr_ptr_reg  <= 1'b0;
    end else if (push) begin
      buf_reg[wr_ptr_reg] <= sensed_reg;
      wr_ptr_reg          <= ~wr_ptr_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_ptr_reg  <= 1'b0;
      cnt_buf_reg <= 2'h0;
    end else begin
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      cnt_buf_reg <= cnt_buf_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // nothing queued means spacing, so keyboard traffic is untouched
  assign o_tx_valid = (cnt_buf_reg != 2'h0);
  always_comb begin
    if (cnt_buf_reg != 2'h0) begin
      o_tx_char = buf_reg[rd_ptr_reg];
    end else begin
      o_tx_char = '0;
    end
  end
  // suppression contact only looked at while a word is queued
  assign o_line_shunt = o_tx_valid && o_tx_char.shunt;
  assign o_busy       = (state_reg != abg_pkg::ABG_IDLE);
  assign o_row        = row_reg;

endmodule

// ---- include/abg_pkg.sv ----
/*
  Package for the answer-back sequence generator: row store layout,
  cycle timing, state encoding and the character carrier struct.
  Assumes one 125 MHz clock and a companion start-stop transmitter.
*/
package abg_pkg;

  // ---------------------------------------------------------------
  // store geometry
  // ---------------------------------------------------------------
  localparam int ROWS       = 21;
  localparam int ROW_W      = 5;
  localparam int CODE_W     = 8;
  localparam int LEVELS     = 11;
  localparam logic [4:0] FIRST_ROW = 5'h00;
  localparam logic [4:0] LAST_ROW  = 5'h14;

  // level positions inside one row word
  localparam int LVL_ADV    = 8;
  localparam int LVL_STOP   = 9;
  localparam int LVL_SUPP   = 10;

  // function slot that carries the call character
  localparam logic [3:0] CALL_SLOT = 4'hF;

  // ---------------------------------------------------------------
  // distributor timing
  // ---------------------------------------------------------------
  localparam int CYCLE_NS   = 100000;
  localparam int CLK_NS     = 8;
  localparam int CYCLE_CLKS = CYCLE_NS / CLK_NS;
  localparam int ADV_LEAD   = 16;

  typedef enum logic [1:0] {
    ABG_IDLE = 2'b00,
    ABG_RUN  = 2'b01,
    ABG_LAST = 2'b11
  } abg_state_t;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic              shunt;
  } abg_char_t;

endpackage

// ---- dv/abg_checker.sv ----
/* checker for abg_generator ports
   assumes one clock, async low reset */
`timescale 1ns/10ps
module abg_checker #(
  parameter int CYCLE_CLKS = 40
) (
  input wire logic               i_clk,
  input wire logic               i_arst_n,
  input wire logic               i_rx_valid,
  input wire logic [3:0]         i_rx_slot,
  input wire logic               i_rx_local,
  input wire logic               i_local_identify_key,
  input wire logic               i_ext_trip,
  input wire logic               i_tx_ready,
  input wire logic               o_tx_valid,
  input wire abg_pkg::abg_char_t o_tx_char,
  input wire logic               o_line_shunt,
  input wire logic               o_busy,
  input wire logic [4:0]         o_row
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_idle; !o_busy; endsequence
  sequence s_call;
    i_rx_valid && !i_rx_local && i_rx_slot == abg_pkg::CALL_SLOT;
  endsequence
  property p_key; s_idle ##0 i_local_identify_key |=> o_busy; endproperty
  a_key: assert property (p_key) else $error("key ignored");
  property p_call; s_idle ##0 s_call |=> o_busy; endproperty
  a_call: assert property (p_call) else $error("call ignored");
  property p_block;
    s_idle ##0 (i_rx_valid && i_rx_local && !i_local_identify_key &&
    !i_ext_trip) |=> !o_busy;
  endproperty
  a_block: assert property (p_block) else $error("local start");
  property p_space; !o_tx_valid |-> o_tx_char == '0 && !o_line_shunt;
  endproperty
  a_space: assert property (p_space) else $error("idle mark");
  property p_shunt;
    o_line_shunt == (o_tx_valid && o_tx_char.shunt);
  endproperty
  a_shunt: assert property (p_shunt) else $error("bad shunt");
  property p_hold;
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_char);
  endproperty
  a_hold: assert property (p_hold) else $error("word lost");
  property p_step;
    o_busy && $past(o_busy) && o_row != $past(o_row) |->
      o_row == $past(o_row) + 5'h01 || o_row == abg_pkg::FIRST_ROW;
  endproperty
  a_step: assert property (p_step) else $error("row skip");
  property p_rest; s_idle ##1 s_idle |-> o_row == abg_pkg::FIRST_ROW;
  endproperty
  a_rest: assert property (p_rest) else $error("row not home");
endmodule
bind abg_generator abg_checker #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_rx_valid(i_rx_valid),
  .i_rx_slot(i_rx_slot), .i_rx_local(i_rx_local),
  .i_local_identify_key(i_local_identify_key), .i_ext_trip(i_ext_trip),
  .i_tx_ready(i_tx_ready), .o_tx_valid(o_tx_valid),
  .o_tx_char(o_tx_char), .o_line_shunt(o_line_shunt),
  .o_busy(o_busy), .o_row(o_row));

// ---- dv/abg_tx_model.sv ----
/* serial transmitter stand-in
   assumes it may stall at random */
`timescale 1ns/10ps
module abg_tx_model (
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  output logic      o_tx_ready
);
  // takes one word per ready cycle, stalls one in four
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) o_tx_ready <= 1'b0;
    else o_tx_ready <= ($urandom % 4) != 0;
  end
endmodule

// ---- dv/tb_answerback_sequence_generator.sv ----
/* bench for abg_generator
   assumes short 40-clock cycles */
`timescale 1ns/10ps
module tb_answerback_sequence_generator;
  // row0 suppress, rows 1-4 message, row5 stop (its code never sent)
  localparam logic [7:0] C_CR   = 8'h08;
  localparam logic [7:0] C_LF   = 8'h02;
  localparam logic [7:0] C_LTRS = 8'h1F;
  localparam logic [7:0] C_D    = 8'h09;
  localparam logic [230:0] STORE = {165'h0, 11'h215, {3'h0, C_D},
    {3'h0, C_LTRS}, {3'h0, C_LF}, {3'h0, C_CR}, 11'h400};
  logic clk = 0, arst_n = 0, rxv = 0, rxl = 0, key = 0, trip = 0;
  logic [3:0] slot = 4'h0;
  logic rdy, txv, shunt, busy;
  logic [4:0] row;
  abg_pkg::abg_char_t txc;
  abg_pkg::abg_char_t exp_q[$];
  abg_pkg::abg_char_t exp_c;
  int fails = 0, n_compared = 0;
  always #4 clk = ~clk;
  abg_generator #(.CYCLE_CLKS(40), .STORE(STORE)) uut (.i_clk(clk),
    .i_arst_n(arst_n), .i_rx_valid(rxv), .i_rx_slot(slot),
    .i_rx_local(rxl), .i_local_identify_key(key), .i_ext_trip(trip),
    .i_tx_ready(rdy), .o_tx_valid(txv), .o_tx_char(txc),
    .o_line_shunt(shunt), .o_busy(busy), .o_row(row));
  abg_tx_model u_tx (.i_clk(clk), .i_arst_n(arst_n), .o_tx_ready(rdy));
  task automatic check(input logic [8:0] seen, exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_busy(input logic lvl);
    int k;
    k = 0;
    while (busy !== lvl && k < 3000) begin
      @(posedge clk);
      k++;
    end
    check(busy, lvl, "busy");
  endtask
  task automatic run_seq(input string name);
    exp_q.push_back({8'h00, 1'b1});
    exp_q.push_back({C_CR, 1'b0});
    exp_q.push_back({C_LF, 1'b0});
    exp_q.push_back({C_LTRS, 1'b0});
    exp_q.push_back({C_D, 1'b0});
    wait_busy(1);
    wait_busy(0);
    repeat (60) @(posedge clk);
    check(9'(exp_q.size()), 0, "words");
    $display("test %s done", name);
  endtask
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    if (arst_n && txv === 1'b1 && rdy === 1'b1) begin
      if (exp_q.size() > 0) begin
        exp_c = exp_q.pop_front();
        check(txc, exp_c, "tx_char");
        check(shunt, exp_c.shunt, "shunt");
      end else begin
        check(1'b1, 1'b0, "extra word");
      end
    end
  end
  initial begin
    #160000;
    fails++;
    wrap_up();
  end
  initial begin
    void'($urandom(83));
    repeat (12) @(posedge clk);
    arst_n <= 1;
    @(posedge clk);
    #1 check({txv, shunt, row}, 0, "idle");
    @(posedge clk) key <= 1;
    @(posedge clk) key <= 0;
    run_seq("key");
    @(posedge clk) {rxv, rxl, slot} <= {2'b11, 4'hF};
    @(posedge clk) {rxl, slot} <= {1'b0, 4'(($urandom % 15))};
    @(posedge clk) rxv <= 0;
    repeat (3) @(posedge clk);
    check(busy, 0, "no start");
    $display("test block done");
    {rxv, slot} <= {1'b1, 4'hF};
    @(posedge clk) rxv <= 0;
    run_seq("call");
    trip <= 1;
    run_seq("trip");
    repeat (100) @(posedge clk);
    check(busy, 0, "retrigger");
    $display("test retrigger done");
    wrap_up();
  end
endmodule
